// [design/mcpi_pkg.sv]
// mcpi_pkg: constants, states and carriers of the motion command interface
// assumes one 125 MHz clock domain shared with the motion core
package mcpi_pkg;

  // register addresses: index in [15:8], subindex in [7:0]
  localparam logic [15:0] ADR_PTP_ABS    = 16'h2301;
  localparam logic [15:0] ADR_PTP_ACK    = 16'h2302;
  localparam logic [15:0] ADR_PTP_REL    = 16'h2303;
  localparam logic [15:0] ADR_PTP_RESUME = 16'h2304;
  localparam logic [15:0] ADR_PTP_SPEED  = 16'h2305;
  localparam logic [15:0] ADR_VEL_SET    = 16'h2401;
  localparam logic [15:0] ADR_VEL_ACK    = 16'h2402;
  localparam logic [15:0] ADR_GEAR_START = 16'h2601;
  localparam logic [15:0] ADR_GEAR_ACK   = 16'h2602;
  localparam logic [15:0] ADR_GEAR_SPEED = 16'h2605;
  localparam logic [15:0] ADR_GEAR_ACCEL = 16'h2606;
  localparam logic [15:0] ADR_GEAR_RATIO = 16'h2607;
  localparam logic [15:0] ADR_IRQ_STAT   = 16'h7f01;
  localparam logic [15:0] ADR_IRQ_MASK   = 16'h7f02;

  // reset values
  localparam logic [31:0] DEF_MOTION_SPEED = 32'h0000_003c;
  localparam logic [31:0] RST_PTP_SPEED    = DEF_MOTION_SPEED;
  localparam logic [31:0] RST_GEAR_SPEED   = 32'h0000_0bb8;
  localparam logic [31:0] RST_GEAR_ACCEL   = 32'h0000_0258;
  localparam logic [31:0] RST_GEAR_RATIO   = 32'h0000_0001;
  localparam logic [15:0] RST_ACK          = 16'h0000;
  localparam logic [3:0]  RST_IRQ          = 4'h0;

  // accepted ranges
  localparam logic [31:0] PTP_SPEED_MIN  = 32'h0000_0001;
  localparam logic [31:0] PTP_SPEED_MAX  = 32'h7fff_ffff;
  localparam logic [31:0] GEAR_SPEED_MIN = 32'h0000_0001;
  localparam logic [31:0] GEAR_SPEED_MAX = 32'h0000_2ee0;
  localparam logic [31:0] GEAR_ACCEL_MIN = 32'h0000_0078;
  localparam logic [31:0] GEAR_ACCEL_MAX = 32'h0001_d4c0;

  // acknowledgement word layout
  localparam logic [7:0]  ACK_FAULT_MASK = 8'hef;
  localparam int unsigned ACK_REACHED    = 13;
  localparam int unsigned ACK_END        = 14;
  localparam int unsigned ACK_ERR        = 15;

  // gearbox processing modes
  localparam logic [15:0] GEAR_OFF  = 16'h0000;
  localparam logic [15:0] GEAR_IMM  = 16'h0001;
  localparam logic [15:0] GEAR_COMP = 16'h0002;

  // interrupt status bits
  localparam int unsigned IRQ_VEL_END  = 0;
  localparam int unsigned IRQ_PTP_END  = 1;
  localparam int unsigned IRQ_GEAR_END = 2;
  localparam int unsigned IRQ_FAULT    = 3;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_VEL  = 4'b0010,
    ST_PTP  = 4'b0100,
    ST_GEAR = 4'b1000
  } mcpi_state_e;

  typedef enum logic [4:0] {
    CMD_NONE   = 5'b00001,
    CMD_VEL    = 5'b00010,
    CMD_PTP    = 5'b00100,
    CMD_RESUME = 5'b01000,
    CMD_GEAR   = 5'b10000
  } mcpi_cmd_e;

  typedef struct packed {
    logic        start;
    mcpi_cmd_e   kind;
    logic [31:0] setpoint;
    logic [31:0] speed;
    logic [1:0]  gear_sync;
  } mcpi_cmd_s;

  typedef struct packed {
    logic [7:0] fault;
    logic       at_speed;
    logic       at_pos;
    logic       done;
  } mcpi_stat_s;

endpackage : mcpi_pkg

// [design/mcpi_top.sv]
// mcpi_top: command registers, acknowledgement words and gearbox scaling
// assumes the motion core runs on clk_in and drives stat_in on that clock
//
// Notes on behaviour
// - writing the speed setpoint starts a ramp towards that signed speed
// - speed ack word: faults bits 0-3,5-7, reached 13, end 14, error 15
// - writing the absolute target starts a move to that position
// - writing the relative travel starts a move from present position
// - any write to resume continues an interrupted move, value ignored
// - move speed accepts 1 to 2147483647, resets to default motion speed
// - gearbox start: 0 off, 1 immediate sync, 2 compensating sync
// - gearbox acceleration limit 120 to 120000, default 600, passed raw
`timescale 1ns/1ps
module mcpi_top (
  // clock and reset
  input  wire logic                 clk_in,
  input  wire logic                 rstn_in,
  // register port
  input  wire logic [15:0]          addr_in,
  input  wire logic [31:0]          wdata_in,
  input  wire logic                 wr_in,
  input  wire logic                 rd_in,
  output logic      [31:0]          rdata_out,
  // motion core
  input  wire mcpi_pkg::mcpi_stat_s stat_in,
  input  wire logic signed [31:0]   position_in,
  input  wire logic signed [15:0]   master_delta_in,
  output mcpi_pkg::mcpi_cmd_s       cmd_out,
  output logic signed [31:0]        gear_speed_out,
  output logic [31:0]               gear_accel_out,
  // interrupt
  output logic                      irq_out
);

  mcpi_pkg::mcpi_state_e state_r, state_nxt;
  mcpi_pkg::mcpi_cmd_s   cmd_r, cmd_nxt;
  logic [31:0] vel_set_r, vel_set_nxt;
  logic [31:0] abs_r, abs_nxt;
  logic [31:0] rel_r, rel_nxt;
  logic [31:0] tgt_r, tgt_nxt;
  logic [15:0] resume_r, resume_nxt;
  logic [31:0] ptp_speed_r, ptp_speed_nxt;
  logic [15:0] gear_mode_r, gear_mode_nxt;
  logic [31:0] gear_lim_r, gear_lim_nxt;
  logic [31:0] accel_r, accel_nxt;
  logic [31:0] ratio_r, ratio_nxt;
  logic [15:0] vel_ack_r, vel_ack_nxt;
  logic [15:0] ptp_ack_r, ptp_ack_nxt;
  logic [15:0] gear_ack_r, gear_ack_nxt;
  logic [3:0]  irq_st_r, irq_st_nxt;
  logic [3:0]  irq_mask_r, irq_mask_nxt;
  logic        irq_r, irq_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic signed [31:0] gspd_r, gspd_nxt;
  logic [3:0]  ev;
  logic        resume_ok;
  logic        fault_any;
  logic signed [47:0] prod;
  logic signed [47:0] lim48;

  function automatic logic in_range(input logic [31:0] v,
                                    input logic [31:0] lo,
                                    input logic [31:0] hi);
    in_range = ($signed(v) >= $signed(lo)) && ($signed(v) <= $signed(hi));
  endfunction : in_range

  function automatic logic hit(input logic wr, input logic [15:0] a,
                               input logic [15:0] off);
    hit = wr && (a == off);
  endfunction : hit

  // collects faults and completion into one ack word
  function automatic logic [15:0] ack_step(input logic [15:0] a,
                                           input mcpi_pkg::mcpi_stat_s s,
                                           input logic reach,
                                           input logic fin);
    logic [7:0] f;
    f = s.fault & mcpi_pkg::ACK_FAULT_MASK;
    ack_step = a | {8'h00, f};
    if (reach) begin
      ack_step[mcpi_pkg::ACK_REACHED] = 1'b1;
    end
    if (|f) begin
      ack_step[mcpi_pkg::ACK_END] = 1'b1;
      ack_step[mcpi_pkg::ACK_ERR] = 1'b1;
    end else if (fin) begin
      ack_step[mcpi_pkg::ACK_END] = 1'b1;
    end
  endfunction : ack_step

  assign fault_any = |(stat_in.fault & mcpi_pkg::ACK_FAULT_MASK);
  assign resume_ok = (state_r != mcpi_pkg::ST_PTP) && ptp_ack_r[mcpi_pkg::ACK_END] &&
                     !ptp_ack_r[mcpi_pkg::ACK_REACHED];
  assign prod      = 48'(master_delta_in) * 48'($signed(ratio_r));
  assign lim48     = $signed({16'h0000, gear_lim_r});

  always_comb begin
    state_nxt     = state_r;
    cmd_nxt       = cmd_r;
    cmd_nxt.start = 1'b0;
    vel_set_nxt   = vel_set_r;
    abs_nxt       = abs_r;
    rel_nxt       = rel_r;
    tgt_nxt       = tgt_r;
    resume_nxt    = resume_r;
    ptp_speed_nxt = ptp_speed_r;
    gear_mode_nxt = gear_mode_r;
    gear_lim_nxt  = gear_lim_r;
    accel_nxt     = accel_r;
    ratio_nxt     = ratio_r;
    vel_ack_nxt   = vel_ack_r;
    ptp_ack_nxt   = ptp_ack_r;
    gear_ack_nxt  = gear_ack_r;
    irq_mask_nxt  = irq_mask_r;
    ev            = 4'h0;
    // progress of the active mode
    unique case (state_r)
      mcpi_pkg::ST_IDLE: begin
      end
      mcpi_pkg::ST_VEL: begin
        vel_ack_nxt = ack_step(vel_ack_r, stat_in, stat_in.at_speed, stat_in.done);
      end
      mcpi_pkg::ST_PTP: begin
        ptp_ack_nxt = ack_step(ptp_ack_r, stat_in, stat_in.at_pos, stat_in.done);
      end
      mcpi_pkg::ST_GEAR: begin
        gear_ack_nxt = ack_step(gear_ack_r, stat_in, 1'b0, 1'b0);
      end
    endcase
    ev[mcpi_pkg::IRQ_VEL_END]  = vel_ack_nxt[mcpi_pkg::ACK_END] &
                                 !vel_ack_r[mcpi_pkg::ACK_END];
    ev[mcpi_pkg::IRQ_PTP_END]  = ptp_ack_nxt[mcpi_pkg::ACK_END] &
                                 !ptp_ack_r[mcpi_pkg::ACK_END];
    ev[mcpi_pkg::IRQ_GEAR_END] = gear_ack_nxt[mcpi_pkg::ACK_END] &
                                 !gear_ack_r[mcpi_pkg::ACK_END];
    ev[mcpi_pkg::IRQ_FAULT]    = (state_r != mcpi_pkg::ST_IDLE) && fault_any;
    if (|ev[2:0]) begin
      state_nxt = mcpi_pkg::ST_IDLE;
    end
    // register writes, a new start overrides the completion above
    if (hit(wr_in, addr_in, mcpi_pkg::ADR_VEL_SET)) begin
      vel_set_nxt      = wdata_in;
      cmd_nxt.start    = 1'b1;
      cmd_nxt.kind     = mcpi_pkg::CMD_VEL;
      cmd_nxt.setpoint = wdata_in;
      vel_ack_nxt      = mcpi_pkg::RST_ACK;
      state_nxt        = mcpi_pkg::ST_VEL;
    end
    if (hit(wr_in, addr_in, mcpi_pkg::ADR_PTP_ABS)) begin
      abs_nxt          = wdata_in;
      tgt_nxt          = wdata_in;
      cmd_nxt.start    = 1'b1;
      cmd_nxt.kind     = mcpi_pkg::CMD_PTP;
      cmd_nxt.setpoint = wdata_in;
      cmd_nxt.speed    = ptp_speed_r;
      ptp_ack_nxt      = mcpi_pkg::RST_ACK;
      state_nxt        = mcpi_pkg::ST_PTP;
    end
    if (hit(wr_in, addr_in, mcpi_pkg::ADR_PTP_REL)) begin
      rel_nxt          = wdata_in;
      tgt_nxt          = 32'(position_in + $signed(wdata_in));
      cmd_nxt.start    = 1'b1;
      cmd_nxt.kind     = mcpi_pkg::CMD_PTP;
      cmd_nxt.setpoint = 32'(position_in + $signed(wdata_in));
      cmd_nxt.speed    = ptp_speed_r;
      ptp_ack_nxt      = mcpi_pkg::RST_ACK;
      state_nxt        = mcpi_pkg::ST_PTP;
    end
    if (hit(wr_in, addr_in, mcpi_pkg::ADR_PTP_RESUME)) begin
      resume_nxt = wdata_in[15:0];
      if (resume_ok) begin
        cmd_nxt.start    = 1'b1;
        cmd_nxt.kind     = mcpi_pkg::CMD_RESUME;
        cmd_nxt.setpoint = tgt_r;
        cmd_nxt.speed    = ptp_speed_r;
        ptp_ack_nxt      = mcpi_pkg::RST_ACK;
        state_nxt        = mcpi_pkg::ST_PTP;
      end
    end
    if (hit(wr_in, addr_in, mcpi_pkg::ADR_PTP_SPEED) &&
        in_range(wdata_in, mcpi_pkg::PTP_SPEED_MIN, mcpi_pkg::PTP_SPEED_MAX)) begin
      ptp_speed_nxt = wdata_in;
    end
    if (hit(wr_in, addr_in, mcpi_pkg::ADR_GEAR_START) &&
        (wdata_in[15:0] <= mcpi_pkg::GEAR_COMP) && (wdata_in[31:16] == 16'h0000)) begin
      gear_mode_nxt     = wdata_in[15:0];
      cmd_nxt.start     = 1'b1;
      cmd_nxt.kind      = mcpi_pkg::CMD_GEAR;
      cmd_nxt.gear_sync = wdata_in[1:0];
      if (wdata_in[15:0] == mcpi_pkg::GEAR_OFF) begin
        if (state_r == mcpi_pkg::ST_GEAR) begin
          gear_ack_nxt[mcpi_pkg::ACK_END] = 1'b1;
          ev[mcpi_pkg::IRQ_GEAR_END]      = !gear_ack_r[mcpi_pkg::ACK_END];
          state_nxt                       = mcpi_pkg::ST_IDLE;
        end
      end else begin
        gear_ack_nxt = mcpi_pkg::RST_ACK;
        state_nxt    = mcpi_pkg::ST_GEAR;
      end
    end
    if (hit(wr_in, addr_in, mcpi_pkg::ADR_GEAR_SPEED) &&
        in_range(wdata_in, mcpi_pkg::GEAR_SPEED_MIN, mcpi_pkg::GEAR_SPEED_MAX)) begin
      gear_lim_nxt = wdata_in;
    end
    if (hit(wr_in, addr_in, mcpi_pkg::ADR_GEAR_ACCEL) &&
        in_range(wdata_in, mcpi_pkg::GEAR_ACCEL_MIN, mcpi_pkg::GEAR_ACCEL_MAX)) begin
      accel_nxt = wdata_in;
    end
    if (hit(wr_in, addr_in, mcpi_pkg::ADR_GEAR_RATIO)) begin
      ratio_nxt = wdata_in;
    end
    if (hit(wr_in, addr_in, mcpi_pkg::ADR_IRQ_MASK)) begin
      irq_mask_nxt = wdata_in[3:0];
    end
    // sticky status, a set in the clearing cycle wins
    irq_st_nxt = irq_st_r & ~(hit(wr_in, addr_in, mcpi_pkg::ADR_IRQ_STAT) ?
                              wdata_in[3:0] : 4'h0);
    irq_st_nxt = irq_st_nxt | ev;
    irq_nxt    = |(irq_st_nxt & irq_mask_nxt);
  end

  // gearbox speed, capped both ways
  always_comb begin
    gspd_nxt = 32'sd0;
    if (state_r == mcpi_pkg::ST_GEAR) begin
      if (prod > lim48) begin
        gspd_nxt = $signed(gear_lim_r);
      end else if (prod < -lim48) begin
        gspd_nxt = -$signed(gear_lim_r);
      end else begin
        gspd_nxt = prod[31:0];
      end
    end
  end

  // read data for the cycle after the strobe
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (rd_in) begin
      unique case (addr_in)
        mcpi_pkg::ADR_PTP_ABS:    rdata_nxt = abs_r;
        mcpi_pkg::ADR_PTP_ACK:    rdata_nxt = {16'h0000, ptp_ack_r};
        mcpi_pkg::ADR_PTP_REL:    rdata_nxt = rel_r;
        mcpi_pkg::ADR_PTP_RESUME: rdata_nxt = {16'h0000, resume_r};
        mcpi_pkg::ADR_PTP_SPEED:  rdata_nxt = ptp_speed_r;
        mcpi_pkg::ADR_VEL_SET:    rdata_nxt = vel_set_r;
        mcpi_pkg::ADR_VEL_ACK:    rdata_nxt = {16'h0000, vel_ack_r};
        mcpi_pkg::ADR_GEAR_START: rdata_nxt = {16'h0000, gear_mode_r};
        mcpi_pkg::ADR_GEAR_ACK:   rdata_nxt = {16'h0000, gear_ack_r};
        mcpi_pkg::ADR_GEAR_SPEED: rdata_nxt = gear_lim_r;
        mcpi_pkg::ADR_GEAR_ACCEL: rdata_nxt = accel_r;
        mcpi_pkg::ADR_GEAR_RATIO: rdata_nxt = ratio_r;
        mcpi_pkg::ADR_IRQ_STAT:   rdata_nxt = {28'h000_0000, irq_st_r};
        mcpi_pkg::ADR_IRQ_MASK:   rdata_nxt = {28'h000_0000, irq_mask_r};
        default:                  rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      state_r     <= mcpi_pkg::ST_IDLE;
      cmd_r       <= '{start: 1'b0, kind: mcpi_pkg::CMD_NONE, setpoint: 32'h0000_0000,
                       speed: 32'h0000_0000, gear_sync: 2'b00};
      vel_set_r   <= 32'h0000_0000;
      abs_r       <= 32'h0000_0000;
      rel_r       <= 32'h0000_0000;
      tgt_r       <= 32'h0000_0000;
      resume_r    <= 16'h0000;
      ptp_speed_r <= mcpi_pkg::RST_PTP_SPEED;
      gear_mode_r <= mcpi_pkg::GEAR_OFF;
      gear_lim_r  <= mcpi_pkg::RST_GEAR_SPEED;
      accel_r     <= mcpi_pkg::RST_GEAR_ACCEL;
      ratio_r     <= mcpi_pkg::RST_GEAR_RATIO;
      vel_ack_r   <= mcpi_pkg::RST_ACK;
      ptp_ack_r   <= mcpi_pkg::RST_ACK;
      gear_ack_r  <= mcpi_pkg::RST_ACK;
      irq_st_r    <= mcpi_pkg::RST_IRQ;
      irq_mask_r  <= mcpi_pkg::RST_IRQ;
      irq_r       <= 1'b0;
      rdata_r     <= 32'h0000_0000;
      gspd_r      <= 32'sd0;
    end else begin
      state_r     <= state_nxt;
      cmd_r       <= cmd_nxt;
      vel_set_r   <= vel_set_nxt;
      abs_r       <= abs_nxt;
      rel_r       <= rel_nxt;
      tgt_r       <= tgt_nxt;
      resume_r    <= resume_nxt;
      ptp_speed_r <= ptp_speed_nxt;
      gear_mode_r <= gear_mode_nxt;
      gear_lim_r  <= gear_lim_nxt;
      accel_r     <= accel_nxt;
      ratio_r     <= ratio_nxt;
      vel_ack_r   <= vel_ack_nxt;
      ptp_ack_r   <= ptp_ack_nxt;
      gear_ack_r  <= gear_ack_nxt;
      irq_st_r    <= irq_st_nxt;
      irq_mask_r  <= irq_mask_nxt;
      irq_r       <= irq_nxt;
      rdata_r     <= rdata_nxt;
      gspd_r      <= gspd_nxt;
    end
  end

  assign rdata_out      = rdata_r;
  assign cmd_out        = cmd_r;
  assign gear_speed_out = gspd_r;
  assign gear_accel_out = accel_r;
  assign irq_out        = irq_r;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  sequence s_ptp_ok_done;
    (state_r == mcpi_pkg::ST_PTP) && stat_in.done && !fault_any && !wr_in;
  endsequence

  sequence s_ptp_ended;
    ptp_ack_r[mcpi_pkg::ACK_END] && !ptp_ack_r[mcpi_pkg::ACK_ERR] &&
    (state_r == mcpi_pkg::ST_IDLE);
  endsequence

  AST_VEL_START: assert property (hit(wr_in, addr_in, mcpi_pkg::ADR_VEL_SET) |=>
    cmd_r.start && (cmd_r.kind == mcpi_pkg::CMD_VEL) && (cmd_r.setpoint == $past(wdata_in))
    ##1 !cmd_r.start || $past(wr_in)) else $error("speed write did not start");
  AST_VEL_LAYOUT: assert property ((vel_ack_r[12:8] == 5'h00) && !vel_ack_r[4] &&
    (!vel_ack_r[mcpi_pkg::ACK_ERR] || vel_ack_r[mcpi_pkg::ACK_END]))
    else $error("speed ack layout broken");
  AST_PTP_ABS: assert property (hit(wr_in, addr_in, mcpi_pkg::ADR_PTP_ABS) |=>
    cmd_r.start && (cmd_r.setpoint == $past(wdata_in)) && (state_r == mcpi_pkg::ST_PTP))
    else $error("absolute move not started");
  AST_PTP_REL: assert property (hit(wr_in, addr_in, mcpi_pkg::ADR_PTP_REL) |=>
    cmd_r.start && (cmd_r.setpoint == 32'($past(position_in) + $signed($past(wdata_in)))))
    else $error("relative target wrong");
  AST_RESUME: assert property (hit(wr_in, addr_in, mcpi_pkg::ADR_PTP_RESUME) &&
    resume_ok |=> cmd_r.start && (cmd_r.kind == mcpi_pkg::CMD_RESUME) &&
    (cmd_r.setpoint == $past(tgt_r))) else $error("resume not issued");
  AST_PTP_SPEED: assert property ($signed(ptp_speed_r) >= 32'sd1)
    else $error("move speed out of range");
  AST_GEAR_IMM: assert property (hit(wr_in, addr_in, mcpi_pkg::ADR_GEAR_START) &&
    (wdata_in == 32'h0000_0001) |=> (state_r == mcpi_pkg::ST_GEAR) &&
    (cmd_r.gear_sync == 2'b01)) else $error("gear start mode wrong");
  AST_ACCEL: assert property ((accel_r >= mcpi_pkg::GEAR_ACCEL_MIN) &&
    (accel_r <= mcpi_pkg::GEAR_ACCEL_MAX) && (gear_accel_out == accel_r))
    else $error("gear accel limit out of range");
  AST_PTP_DONE: assert property (s_ptp_ok_done |=> s_ptp_ended)
    else $error("move end not acknowledged");
  AST_GEAR_B13: assert property (!gear_ack_r[mcpi_pkg::ACK_REACHED])
    else $error("gear ack bit 13 set");
  AST_GEAR_CAP: assert property ((state_r == mcpi_pkg::ST_GEAR) && !wr_in |=>
    ($signed(gspd_r) <= $signed(gear_lim_r)) && ($signed(gspd_r) >= -$signed(gear_lim_r)))
    else $error("gear speed above limit");
  AST_IRQ: assert property (irq_out == |(irq_st_r & irq_mask_r))
    else $error("irq does not follow status");

endmodule : mcpi_top

// [verification/mcpi_core_model.sv]
// mcpi_core_model: motion core stand-in that answers speed, move and resume command pulses after a delay, gearbox ones never
// assumes cmd_in comes from mcpi_top on the same clock; fault_in chosen by the bench
`timescale 1ns/1ps
module mcpi_core_model (
  // clock and reset
  input  wire logic                 clk_in,
  input  wire logic                 rstn_in,
  // command side
  input  wire mcpi_pkg::mcpi_cmd_s  cmd_in,
  input  wire logic [7:0]           fault_in,
  input  wire logic signed [15:0]   delta_in,
  // status side
  output mcpi_pkg::mcpi_stat_s      stat_out,
  output logic signed [31:0]        position_out,
  output logic signed [15:0]        master_delta_out
);
  localparam int DELAY = 5;
  int cnt;
  assign master_delta_out = delta_in;
  // status is a one-cycle report, quiet otherwise
  always @(posedge clk_in) begin
    stat_out <= '0;
    if (!rstn_in) begin
      cnt          <= 0;
      position_out <= '0;
    end else if (cmd_in.start && cmd_in.kind != mcpi_pkg::CMD_GEAR) begin
      cnt <= DELAY;
    end else if (cnt == 1) begin
      cnt <= 0;
      if (fault_in != 8'h00) begin
        stat_out.fault <= fault_in;
      end else begin
        stat_out.at_speed <= cmd_in.kind == mcpi_pkg::CMD_VEL;
        stat_out.at_pos   <= cmd_in.kind != mcpi_pkg::CMD_VEL;
        stat_out.done     <= 1'b1;
        if (cmd_in.kind != mcpi_pkg::CMD_VEL) begin
          position_out <= cmd_in.setpoint;
        end
      end
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule : mcpi_core_model

// [verification/mcpi_top_tb.sv]
// mcpi_top_tb: register-level tests of the motion command interface
// assumes mcpi_core_model answers each move or speed command after a fixed delay
`timescale 1ns/1ps
module mcpi_top_tb;
  logic                 clk_in, rstn_in, wr_in, rd_in, irq_out;
  logic [15:0]          addr_in;
  logic [31:0]          wdata_in, rdata_out, rd_val, gear_accel;
  logic [7:0]           fault;
  logic signed [15:0]   delta, mdelta;
  logic signed [31:0]   position, gear_speed;
  mcpi_pkg::mcpi_stat_s stat;
  mcpi_pkg::mcpi_cmd_s  cmd;
  int                   num_errors, checks;
  logic [15:0] ra[11] = '{16'h2305, 16'h2605, 16'h2606, 16'h2607, 16'h2402, 16'h2302,
                          16'h2602, 16'h2399, 16'h7f01, 16'h7f02, 16'h2398};
  logic [31:0] rv[11] = '{32'h0000_003c, 32'h0000_0bb8, 32'h0000_0258, 32'h0000_0001,
                          32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
  logic [15:0] wa[11] = '{16'h2305, 16'h2305, 16'h2305, 16'h2305, 16'h2606, 16'h2606,
                          16'h2606, 16'h2606, 16'h2605, 16'h2605, 16'h2399};
  logic [31:0] wd[11] = '{32'h0, 32'h7fff_ffff, 32'h8000_0000, 32'h1, 32'h77, 32'h78,
                          32'h1_d4c0, 32'h1_d4c1, 32'h0, 32'h2ee1, 32'h5};
  logic [31:0] we[11] = '{32'h3c, 32'h7fff_ffff, 32'h7fff_ffff, 32'h1, 32'h258, 32'h78,
                          32'h1_d4c0, 32'h1_d4c0, 32'hbb8, 32'hbb8, 32'h0};
  logic signed [15:0] gd[3] = '{16'sd7, 16'sd1000, -16'sd1000};
  logic [31:0] ge[3] = '{32'h0000_0023, 32'h0000_0bb8, 32'hffff_f448};

  mcpi_top u_dut (.clk_in(clk_in), .rstn_in(rstn_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .stat_in(stat), .position_in(position), .master_delta_in(mdelta), .cmd_out(cmd),
    .gear_speed_out(gear_speed), .gear_accel_out(gear_accel), .irq_out(irq_out));
  mcpi_core_model u_core (.clk_in(clk_in), .rstn_in(rstn_in), .cmd_in(cmd),
    .fault_in(fault), .delta_in(delta), .stat_out(stat), .position_out(position),
    .master_delta_out(mdelta));

  task automatic stop_test;
    if (num_errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk_in);
    wr_in    <= 1'b1;
    addr_in  <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [15:0] a);
    @(posedge clk_in);
    rd_in   <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    rd_val = rdata_out;
  endtask : rd
  task automatic rchk(input logic [15:0] a, input logic [31:0] exp);
    rd(a);
    chk(rd_val, exp);
  endtask : rchk
  // poll an ack word until its end flag shows, then compare the whole word
  task automatic wait_ack(input logic [15:0] a, input logic [31:0] exp);
    for (int i = 0; i < 20; i++) begin
      rd(a);
      if (rd_val[14] === 1'b1) break;
    end
    chk(rd_val, exp);
  endtask : wait_ack
  task automatic cmd_chk(input mcpi_pkg::mcpi_cmd_e k, input logic [31:0] sp);
    chk(32'(cmd.start), 32'h1);
    chk(32'(cmd.kind), 32'(k));
    chk(cmd.setpoint, sp);
  endtask : cmd_chk
  task automatic irq_chk(input logic exp);
    @(posedge clk_in);
    #1;
    chk(32'(irq_out), 32'(exp));
  endtask : irq_chk

  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  initial begin
    #200000;
    num_errors++;
    stop_test();
  end
  initial begin
    rstn_in  = 1'b0;
    wr_in    = 1'b0;
    rd_in    = 1'b0;
    addr_in  = 16'h0000;
    wdata_in = 32'h0000_0000;
    fault    = 8'h00;
    delta    = 16'sd0;
    repeat (4) @(posedge clk_in);
    rstn_in <= 1'b1;
    foreach (ra[i]) rchk(ra[i], rv[i]);
    chk(gear_accel, 32'h0000_0258);
    foreach (wa[i]) begin
      wr(wa[i], wd[i]);
      rchk(wa[i], we[i]);
    end
    // speed mode with reached and end
    wr(16'h2401, 32'hffff_ff9c);
    cmd_chk(mcpi_pkg::CMD_VEL, 32'hffff_ff9c);
    wait_ack(16'h2402, 32'h0000_6000);
    rchk(16'h7f01, 32'h0000_0001);
    irq_chk(1'b0);
    wr(16'h7f02, 32'h0000_0001);
    irq_chk(1'b1);
    wr(16'h7f01, 32'h0000_0001);
    irq_chk(1'b0);
    // absolute move ends in a fault, then resume completes it
    fault <= 8'hff;
    wr(16'h2301, 32'h0000_1234);
    cmd_chk(mcpi_pkg::CMD_PTP, 32'h0000_1234);
    chk(cmd.speed, 32'h0000_0001);
    wait_ack(16'h2302, 32'h0000_c0ef);
    rchk(16'h7f01, 32'h0000_000a);
    fault <= 8'h00;
    wr(16'h2304, 32'h0000_abcd);
    cmd_chk(mcpi_pkg::CMD_RESUME, 32'h0000_1234);
    wait_ack(16'h2302, 32'h0000_6000);
    wr(16'h2304, 32'h0000_0000);
    chk(32'(cmd.start), 32'h0);
    wr(16'h2303, 32'hffff_fff0);
    cmd_chk(mcpi_pkg::CMD_PTP, 32'h0000_1224);
    wait_ack(16'h2302, 32'h0000_6000);
    // gearbox modes, scaling and cap
    wr(16'h2607, 32'h0000_0005);
    for (int m = 1; m < 3; m++) begin
      wr(16'h2601, 32'(m));
      cmd_chk(mcpi_pkg::CMD_GEAR, 32'h0000_1224);
      chk(32'(cmd.gear_sync), 32'(m));
    end
    wr(16'h2601, 32'h0000_0003);
    chk(32'(cmd.start), 32'h0);
    foreach (gd[i]) begin
      @(posedge clk_in);
      delta <= gd[i];
      repeat (2) @(posedge clk_in);
      #1;
      chk(gear_speed, ge[i]);
    end
    wr(16'h2601, 32'h0000_0000);
    rchk(16'h2602, 32'h0000_4000);
    chk(gear_speed, 32'h0);
    stop_test();
  end
endmodule : mcpi_top_tb
